//--- hdl/dtc_top.sv
// Dual timer/counter with run/gate control, external interrupt flags,
// PWM and overflow toggle outputs, behind an AHB-Lite register slave.
// Assumes a single AHB-Lite master, single word transfers, one core clock.
// Function
// R1: Prescaled mode counts 13 bits: high byte plus low five bits of low byte.
// R2: Overflow flag sets when the count rolls from all ones to zero.
// R3: Counting only when run bit set and gate off or gate pin high.
// R4: Setting a run bit never changes the count registers.
// R5: Each timer has its own gate select in the mode register.
// R6: 16-bit mode uses the full high and low count bytes.
// R7: Auto-reload: low byte counts, overflow sets flag and reloads from high byte.
// R8: Second timer in split mode stops as if its run bit were clear.
// R9: First timer split: low byte uses first timer's controls and flag.
// R10: First timer split: high byte counts cycles on second run bit, sets second flag.
// R11: Second timer then runs unless in its own split mode, without a flag.
// R12: PWM mode behaves like auto-reload with a 256-clock period.
// R13: In PWM mode hardware both sets and clears the overflow flag.
// R14: Software keeps the PWM high byte within 1 to 254.
// R15: PWM high period equals 256 minus the high byte.
// R16: PWM high byte 00h forces the pin high, FFh forces it low.
// R17: In PWM mode the flag rise still interrupts and software may clear it.
// R18: Interrupt type bit set selects falling edge, clear selects low level.
// R19: Edge flag set on detected edge, cleared on service or by software.
// R20: Overflow flags clear on vectoring or by software except in PWM mode; here vectoring clears them in PWM mode as well.
// R21: Toggle enable flips the timer pin on every overflow.
// R22: Toggle output reads one until first overflow; needs internal clocking.
// R23: Mode bits select prescaled, 16-bit, reload, split or PWM modes.
// R24: Counter select chooses core clock or external count pin events.
// R25: Count pin is synchronised and counted on each falling transition.
`timescale 1ns/1ns
module dtc_top (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [1:0] i_gate_input_pin,
  input wire logic [1:0] i_count_pin,
  output logic [1:0] o_count_pin_out,
  output logic [1:0] o_count_pin_oe_b,
  input wire logic [1:0] i_tmr_irq_ack,
  input wire logic [1:0] i_ext_irq_ack,
  output logic [1:0] o_tmr_irq_req,
  output logic [1:0] o_ext_irq_req
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [7:0] tctrl;
    logic [7:0] tmode;
    logic [7:0] tmode_hi;
    logic [1:0] tog_en;
    logic [1:0][7:0] tl;
    logic [1:0][7:0] th;
    logic [1:0] pwm_hi;
    logic [1:0] tog;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_b;
    logic [1:0] ext_req;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] addr;
    logic hready;
    logic [31:0] hrdata;
  } dtc_st_t;

  dtc_st_t q_ff;
  dtc_st_t nxt_q;

  logic [N_PIN-1:0] pin_lvl;
  logic [N_PIN-1:0] pin_fall;
  logic [1:0][2:0] mode;
  logic [1:0] gate_lvl;
  logic [1:0] cnt_fall;
  logic [1:0] csel;
  logic [1:0] tick;
  logic [1:0] hi_tick;
  logic [1:0] ovf;
  logic [1:0] hi_ovf;
  logic [1:0][7:0] step_tl;
  logic [1:0][7:0] step_th;
  logic t0_split;
  logic t1_split;
  logic addr_ok;

  // Gate pins in bits 1:0, count pins in bits 3:2
  dtc_pin_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_pin({i_count_pin, i_gate_input_pin}),
    .o_lvl(pin_lvl),
    .o_fall(pin_fall)
  );

  assign gate_lvl = pin_lvl[1:0];
  assign cnt_fall = pin_fall[3:2];
  assign mode[0] = {q_ff.tmode_hi[B_M0_HI], q_ff.tmode[B_M0_LO+1:B_M0_LO]};
  assign mode[1] = {q_ff.tmode_hi[B_M1_HI], q_ff.tmode[B_M1_LO+1:B_M1_LO]};
  assign csel = {q_ff.tmode[B_CSEL1], q_ff.tmode[B_CSEL0]};
  assign t0_split = (mode[0] == MODE_SPLIT);
  assign t1_split = (mode[1] == MODE_SPLIT);

  always_comb begin
    // First timer: run bit and its own gate select
    tick[0] = q_ff.tctrl[B_RUN0] & (~q_ff.tmode[B_GATE0] | gate_lvl[0]) // [R3] [R5]
              & (csel[0] ? cnt_fall[0] : 1'b1); // [R24]
    // Second timer loses its run bit to the split first timer
    tick[1] = (t0_split ? 1'b1 : q_ff.tctrl[B_RUN1]) & ~t1_split // [R8] [R11]
              & (~q_ff.tmode[B_GATE1] | gate_lvl[1]) // [R3] [R5]
              & (csel[1] ? cnt_fall[1] : 1'b1); // [R24]
    hi_tick[0] = t0_split & q_ff.tctrl[B_RUN1]; // [R10]
    hi_tick[1] = 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      dtc_step u_step (
        .i_mode(mode[gi]),
        .i_tl(q_ff.tl[gi]),
        .i_th(q_ff.th[gi]),
        .i_cnt(tick[gi]),
        .i_hi_cnt(hi_tick[gi]),
        .i_pwm_hi(q_ff.pwm_hi[gi]),
        .o_tl(step_tl[gi]),
        .o_th(step_th[gi]),
        .o_ovf(ovf[gi]),
        .o_hi_ovf(hi_ovf[gi])
      );
    end
  endgenerate

  function automatic logic [7:0] rd_mux(input dtc_st_t s);
    logic [7:0] v;
    v = 8'h00;
    case (s.addr)
      ADDR_TCTRL: v = s.tctrl;
      ADDR_TMODE: v = s.tmode;
      ADDR_TMODE_HI: v = s.tmode_hi;
      ADDR_AUX: v = {6'h00, s.tog_en};
      ADDR_TL0: v = s.tl[0];
      ADDR_TH0: v = s.th[0];
      ADDR_TL1: v = s.tl[1];
      ADDR_TH1: v = s.th[1];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  assign addr_ok = i_hsel & i_hready & i_htrans[1];

  always_comb begin
    logic wr;
    logic [7:0] wd;
    logic [1:0] tf_set;
    logic [1:0] tf_clr;
    logic [1:0] is_pwm;
    logic [1:0] tog_ovf;
    wr = q_ff.wr_pend;
    wd = i_hwdata[7:0];
    tf_set = 2'b00;
    tf_clr = 2'b00;
    is_pwm = 2'b00;
    tog_ovf = 2'b00;
    nxt_q = q_ff;

    // Bus: writes commit in the data phase, reads take one wait state
    nxt_q.wr_pend = addr_ok & i_hwrite;
    nxt_q.rd_pend = addr_ok & ~i_hwrite;
    nxt_q.hready = ~(addr_ok & ~i_hwrite);
    if (addr_ok) begin
      nxt_q.addr = i_haddr;
    end
    if (q_ff.rd_pend) begin
      nxt_q.hrdata = {24'h000000, rd_mux(q_ff)};
    end

    // Counting, then software writes to the count bytes take priority
    nxt_q.tl = step_tl;
    nxt_q.th = step_th;
    if (wr) begin
      case (q_ff.addr)
        ADDR_TMODE: nxt_q.tmode = wd;
        ADDR_TMODE_HI: nxt_q.tmode_hi = wd;
        ADDR_AUX: nxt_q.tog_en = {wd[B_TOG1], wd[B_TOG0]};
        ADDR_TL0: nxt_q.tl[0] = wd;
        ADDR_TH0: nxt_q.th[0] = wd;
        ADDR_TL1: nxt_q.tl[1] = wd;
        ADDR_TH1: nxt_q.th[1] = wd;
        // Control write replaces run, flag and interrupt type bits; counts kept
        ADDR_TCTRL: nxt_q.tctrl = wd; // [R4]
        default: nxt_q.tmode = q_ff.tmode;
      endcase
    end

    // Overflow flags
    for (int i = 0; i < 2; i++) begin
      is_pwm[i] = (mode[i] == MODE_PWM);
      if (ovf[i] && is_pwm[i]) begin
        nxt_q.pwm_hi[i] = ~q_ff.pwm_hi[i];
      end
      tf_set[i] = ovf[i] & ~(is_pwm[i] & q_ff.pwm_hi[i]); // [R2] [R13] [R17]
      tf_clr[i] = i_tmr_irq_ack[i] | (ovf[i] & is_pwm[i] & q_ff.pwm_hi[i]); // [R13] [R20]
    end
    // Split first timer: high byte owns the second flag, second timer has none
    if (t0_split) begin
      tf_set[1] = hi_ovf[0]; // [R10] [R11]
    end
    nxt_q.tctrl[B_TF0] = tf_set[0] | (nxt_q.tctrl[B_TF0] & ~tf_clr[0]); // [R20]
    nxt_q.tctrl[B_TF1] = tf_set[1] | (nxt_q.tctrl[B_TF1] & ~tf_clr[1]); // [R20]

    // External interrupt edge flags; set wins over any clear
    nxt_q.tctrl[B_IE_A] = (q_ff.tctrl[B_IT_A] & pin_fall[0]) // [R18] [R19]
                          | (nxt_q.tctrl[B_IE_A] & ~i_ext_irq_ack[0]);
    nxt_q.tctrl[B_IE_B] = (q_ff.tctrl[B_IT_B] & pin_fall[1]) // [R18] [R19]
                          | (nxt_q.tctrl[B_IE_B] & ~i_ext_irq_ack[1]);
    nxt_q.ext_req[0] = q_ff.tctrl[B_IT_A] ? nxt_q.tctrl[B_IE_A] : ~gate_lvl[0]; // [R18]
    nxt_q.ext_req[1] = q_ff.tctrl[B_IT_B] ? nxt_q.tctrl[B_IE_B] : ~gate_lvl[1]; // [R18]

    // Toggle and PWM pin outputs
    for (int i = 0; i < 2; i++) begin
      tog_ovf[i] = ovf[i] & q_ff.tog_en[i] & ~csel[i]; // [R22]
      if (nxt_q.tog_en[i] && !q_ff.tog_en[i]) begin
        nxt_q.tog[i] = 1'b1; // [R22]
      end else if (tog_ovf[i]) begin
        nxt_q.tog[i] = ~q_ff.tog[i]; // [R21]
      end
      if (is_pwm[i]) begin
        if (nxt_q.th[i] == BYTE_ZERO) begin
          nxt_q.pin_out[i] = 1'b1; // [R16]
        end else if (nxt_q.th[i] == BYTE_MAX) begin
          nxt_q.pin_out[i] = 1'b0; // [R16]
        end else begin
          nxt_q.pin_out[i] = nxt_q.pwm_hi[i]; // [R12] [R15]
        end
      end else if (nxt_q.tog_en[i]) begin
        nxt_q.pin_out[i] = nxt_q.tog[i]; // [R21]
      end else begin
        nxt_q.pin_out[i] = 1'b1;
      end
      nxt_q.pin_oe_b[i] = ~(is_pwm[i] | nxt_q.tog_en[i]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_ff <= '0;
      q_ff.tctrl <= TCTRL_RST;
      q_ff.tmode <= TMODE_RST;
      q_ff.hready <= 1'b1;
      q_ff.pin_out <= 2'b11;
      q_ff.pin_oe_b <= 2'b11;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_hreadyout = q_ff.hready;
  assign o_hresp = 1'b0;
  assign o_hrdata = q_ff.hrdata;
  assign o_count_pin_out = q_ff.pin_out;
  assign o_count_pin_oe_b = q_ff.pin_oe_b;
  assign o_tmr_irq_req = {q_ff.tctrl[B_TF1], q_ff.tctrl[B_TF0]};
  assign o_ext_irq_req = q_ff.ext_req;

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_prescale_wrap;
    mode[0] == MODE_PRESCALE && tick[0] && q_ff.tl[0][PRE_W-1:0] == PRE_MAX
      && q_ff.th[0] == BYTE_MAX && !q_ff.wr_pend
      |=> q_ff.tl[0][PRE_W-1:0] == 5'h00 && q_ff.th[0] == BYTE_ZERO
          && q_ff.tl[0][7:PRE_W] == $past(q_ff.tl[0][7:PRE_W]);
  endproperty
  a_prescale_wrap: assert property (p_prescale_wrap) else $error("prescale wrap wrong"); // [R1]

  property p_ovf_flag;
    ovf[0] && mode[0] != MODE_PWM |=> o_tmr_irq_req[0];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set"); // [R2]

  property p_run_off;
    !q_ff.tctrl[B_RUN0] && !q_ff.wr_pend |=> $stable(q_ff.tl[0]);
  endproperty
  a_run_off: assert property (p_run_off) else $error("counted while stopped"); // [R3]

  property p_gate_hold;
    q_ff.tmode[B_GATE0] && !gate_lvl[0] && !t0_split && !q_ff.wr_pend
      |=> $stable(q_ff.tl[0]) && $stable(q_ff.th[0]);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate ignored"); // [R5]

  property p_reload;
    mode[0] == MODE_RELOAD && tick[0] && q_ff.tl[0] == BYTE_MAX && !q_ff.wr_pend
      |=> q_ff.tl[0] == $past(q_ff.th[0]) && $stable(q_ff.th[0]) && o_tmr_irq_req[0];
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong"); // [R7]

  property p_t1_stop;
    t1_split && !q_ff.wr_pend |=> $stable(q_ff.tl[1]) && $stable(q_ff.th[1]);
  endproperty
  a_t1_stop: assert property (p_t1_stop) else $error("second timer ran in split"); // [R8]

  property p_split_hi;
    t0_split && q_ff.tctrl[B_RUN1] && q_ff.th[0] == BYTE_MAX && !q_ff.wr_pend
      |=> o_tmr_irq_req[1] && q_ff.th[0] == BYTE_ZERO;
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("split high byte wrong"); // [R10]

  property p_pwm_force;
    mode[0] == MODE_PWM && q_ff.th[0] == BYTE_ZERO && !q_ff.wr_pend
      |=> o_count_pin_out[0] && !o_count_pin_oe_b[0];
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("pwm not forced high"); // [R16]

  property p_ext_edge;
    q_ff.tctrl[B_IT_B] && pin_fall[1] |=> q_ff.tctrl[B_IE_B] && o_ext_irq_req[1];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("edge flag missed"); // [R19]

  property p_tog_first;
    $rose(q_ff.tog_en[0]) |-> q_ff.tog[0];
  endproperty
  a_tog_first: assert property (p_tog_first) else $error("toggle not one at start"); // [R22]

  property p_read_wait;
    addr_ok && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

  c_prescale: cover property (mode[0] == MODE_PRESCALE && ovf[0]);
  c_pwm_rise: cover property (mode[1] == MODE_PWM && $rose(o_tmr_irq_req[1]));
  c_split_hi: cover property (t0_split && hi_ovf[0]);
  c_ext_edge: cover property (q_ff.tctrl[B_IT_B] && pin_fall[1]);

endmodule : dtc_top

//--- hdl/dtc_pkg.sv
// Shared constants for the dual timer/counter block.
// Assumes an AHB-Lite register port with 32-bit data and one core clock.
package dtc_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_TCTRL = 32'h0000_0088;
  localparam logic [31:0] ADDR_TMODE = 32'h0000_008c;
  localparam logic [31:0] ADDR_TMODE_HI = 32'h0000_0090;
  localparam logic [31:0] ADDR_AUX = 32'h0000_0094;
  localparam logic [31:0] ADDR_TL0 = 32'h0000_0098;
  localparam logic [31:0] ADDR_TH0 = 32'h0000_009c;
  localparam logic [31:0] ADDR_TL1 = 32'h0000_00a0;
  localparam logic [31:0] ADDR_TH1 = 32'h0000_00a4;

  // Reset values
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] TMODE_RST = 8'h00;

  // timer_run_and_ext_irq_control fields
  localparam int B_IT_A = 0;
  localparam int B_IE_A = 1;
  localparam int B_IT_B = 2;
  localparam int B_IE_B = 3;
  localparam int B_RUN0 = 4;
  localparam int B_TF0 = 5;
  localparam int B_RUN1 = 6;
  localparam int B_TF1 = 7;

  // timer_mode_reg fields
  localparam int B_M0_LO = 0;
  localparam int B_CSEL0 = 2;
  localparam int B_GATE0 = 3;
  localparam int B_M1_LO = 4;
  localparam int B_CSEL1 = 6;
  localparam int B_GATE1 = 7;

  // Upper mode bit register and auxiliary_control_reg fields
  localparam int B_M0_HI = 0;
  localparam int B_M1_HI = 4;
  localparam int B_TOG0 = 0;
  localparam int B_TOG1 = 1;

  // mode_select_bits encodings
  localparam logic [2:0] MODE_PRESCALE = 3'h0;
  localparam logic [2:0] MODE_16BIT = 3'h1;
  localparam logic [2:0] MODE_RELOAD = 3'h2;
  localparam logic [2:0] MODE_SPLIT = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h6;

  // Counter shapes
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_MAX = 5'h1f;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int N_PIN = 4;

endpackage : dtc_pkg

//--- hdl/dtc_pin_sync.sv
// Two-flop synchronisers and falling-edge detect for the external pins.
// Assumes asynchronous pins; outputs are in the core clock domain.
`timescale 1ns/1ns
module dtc_pin_sync (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [dtc_pkg::N_PIN-1:0] i_pin,
  output logic [dtc_pkg::N_PIN-1:0] o_lvl,
  output logic [dtc_pkg::N_PIN-1:0] o_fall
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [N_PIN-1:0] s1;
    logic [N_PIN-1:0] s2;
    logic [N_PIN-1:0] s3;
  } dtc_sync_t;

  dtc_sync_t q_ff;
  dtc_sync_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = i_pin;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
  end

  // Idle-high reset keeps a released reset from looking like an edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_ff <= '1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_lvl = q_ff.s2;
  assign o_fall = q_ff.s3 & ~q_ff.s2; // [R25]

endmodule : dtc_pin_sync

//--- hdl/dtc_step.sv
// Next-count logic of one timer for every mode.
// Assumes tick inputs are single-cycle enables from the core clock domain.
`timescale 1ns/1ns
module dtc_step (
  input wire logic [2:0] i_mode,
  input wire logic [7:0] i_tl,
  input wire logic [7:0] i_th,
  input wire logic i_cnt,
  input wire logic i_hi_cnt,
  input wire logic i_pwm_hi,
  output logic [7:0] o_tl,
  output logic [7:0] o_th,
  output logic o_ovf,
  output logic o_hi_ovf
);
  import dtc_pkg::*;

  always_comb begin
    o_tl = i_tl;
    o_th = i_th;
    o_ovf = 1'b0;
    o_hi_ovf = 1'b0;
    case (i_mode) // [R23]
      MODE_PRESCALE: begin
        if (i_cnt) begin
          // Upper low-byte bits are left as they are
          o_tl[PRE_W-1:0] = i_tl[PRE_W-1:0] + 5'h01; // [R1]
          if (i_tl[PRE_W-1:0] == PRE_MAX) begin
            o_th = i_th + 8'h01;
            o_ovf = (i_th == BYTE_MAX); // [R2]
          end
        end
      end
      MODE_16BIT: begin
        if (i_cnt) begin
          o_tl = i_tl + 8'h01; // [R6]
          if (i_tl == BYTE_MAX) begin
            o_th = i_th + 8'h01;
            o_ovf = (i_th == BYTE_MAX);
          end
        end
      end
      MODE_RELOAD, MODE_PWM: begin
        if (i_cnt) begin
          if (i_tl == BYTE_MAX) begin
            o_ovf = 1'b1; // [R7]
            // PWM alternates a th-long low phase and a (256-th)-long high phase
            if (i_mode == MODE_PWM && i_pwm_hi) begin
              o_tl = BYTE_ZERO - i_th; // [R12] [R15]
            end else begin
              o_tl = i_th;
            end
          end else begin
            o_tl = i_tl + 8'h01;
          end
        end
      end
      MODE_SPLIT: begin
        if (i_cnt) begin
          o_tl = i_tl + 8'h01; // [R9]
          o_ovf = (i_tl == BYTE_MAX);
        end
        if (i_hi_cnt) begin
          o_th = i_th + 8'h01; // [R10]
          o_hi_ovf = (i_th == BYTE_MAX);
        end
      end
      default: begin
        o_tl = i_tl;
      end
    endcase
  end

endmodule : dtc_step

//--- sim/dtc_pin_model.sv
// Far-side model of the timer pins: gate/interrupt pins and shared count pins.
// Assumes the bench calls its tasks from the core clock domain.
`timescale 1ns/1ns
module dtc_pin_model (
  input wire logic i_core_clk,
  input wire logic [1:0] i_pin_out,
  input wire logic [1:0] i_pin_oe_b,
  output logic [1:0] o_gate_pin,
  output logic [1:0] o_count_pin
);
  logic [1:0] drv;

  initial begin
    o_gate_pin = 2'b00;
    drv = 2'b11;
  end

  // The block owns the wire while its enable is low
  assign o_count_pin = (i_pin_oe_b & drv) | (~i_pin_oe_b & i_pin_out);

  task automatic set_gate(input int b, input logic v);
    @(posedge i_core_clk);
    o_gate_pin[b] <= v;
  endtask : set_gate

  // Each level is held well beyond the synchroniser delay
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      drv[b] <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      drv[b] <= 1'b1;
      repeat (3) @(posedge i_core_clk);
    end
  endtask : pulse
endmodule : dtc_pin_model

//--- sim/dual_timer_counter_modes_bench.sv
// Self-checking bench for the dual timer/counter block.
// Assumes one AHB-Lite master (this bench) and the pin model on the far side.
`timescale 1ns/1ns
module dual_timer_counter_modes_bench;
  import dtc_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] hsize;
  logic [1:0] htrans, tmr_ack, ext_ack, pin_out, pin_oe_b, tmr_req, ext_req;
  logic [1:0] gate_pin, cnt_pin;
  logic [5:0] mon;
  int n_errors, checked, cyc, hi, lo;

  assign mon = {ext_req, tmr_req, pin_out};

  dtc_top i_dtc_top (
    .i_core_clk(core_clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_gate_input_pin(gate_pin), .i_count_pin(cnt_pin),
    .o_count_pin_out(pin_out), .o_count_pin_oe_b(pin_oe_b),
    .i_tmr_irq_ack(tmr_ack), .i_ext_irq_ack(ext_ack),
    .o_tmr_irq_req(tmr_req), .o_ext_irq_req(ext_req)
  );

  dtc_pin_model i_dtc_pin_model (
    .i_core_clk(core_clk), .i_pin_out(pin_out), .i_pin_oe_b(pin_oe_b),
    .o_gate_pin(gate_pin), .o_count_pin(cnt_pin)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // One single transfer; ready is sampled at the falling edge before the rising edge that ends each phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    logic rdy;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(negedge core_clk);
      rdy = hreadyout;
      @(posedge core_clk);
    end while (!rdy);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(negedge core_clk);
      rdy = hreadyout;
      q = hrdata;
      @(posedge core_clk);
    end while (!rdy);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input string s, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(s, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic wait_bit(input string s, input int k, input logic v);
    int i;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (mon[k] !== v && i < 700);
    chk(s, {31'h0, v}, {31'h0, mon[k]});
    @(posedge core_clk);
  endtask : wait_bit

  // Length of the next full high run and the low run after it
  task automatic run_len(input int k);
    hi = 0;
    lo = 0;
    wait_bit("run_low", k, 1'b0);
    wait_bit("run_high", k, 1'b1);
    do begin
      @(negedge core_clk);
      hi++;
    end while (mon[k] === 1'b1 && hi < 600);
    do begin
      @(negedge core_clk);
      lo++;
    end while (mon[k] === 1'b0 && lo < 600);
    @(posedge core_clk);
  endtask : run_len

  task automatic ack(input int b, input logic ext);
    @(posedge core_clk);
    if (ext) ext_ack[b] <= 1'b1;
    else tmr_ack[b] <= 1'b1;
    @(posedge core_clk);
    ext_ack <= 2'b00;
    tmr_ack <= 2'b00;
  endtask : ack

  initial begin
    n_errors = 0;
    checked = 0;
    cyc = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tmr_ack = 2'b00;
    ext_ack = 2'b00;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rchk("ctrl_reset", ADDR_TCTRL, {24'h0, TCTRL_RST});
    rchk("unmapped", 32'h0000_00c0, 32'h0);
    // Gate select on, gate pin low: run bit alone must not count
    wr(ADDR_TMODE, 8'h09);
    wr(ADDR_TL0, 8'h12);
    wr(ADDR_TH0, 8'h34);
    wr(ADDR_TCTRL, 8'h10);
    repeat (10) @(posedge core_clk);
    rchk("tl0_gated", ADDR_TL0, 32'h12);
    rchk("th0_gated", ADDR_TH0, 32'h34);
    wait_bit("ext_a_level", 4, 1'b1);
    wr(ADDR_TL0, 8'hf0);
    wr(ADDR_TH0, 8'hff);
    i_dtc_pin_model.set_gate(0, 1'b1);
    wait_bit("ovf_16bit", 2, 1'b1);
    rchk("th0_wrapped", ADDR_TH0, 32'h00);
    ack(0, 1'b0);
    wait_bit("ovf_ack", 2, 1'b0);
    // Prescaled: 13-bit all ones rolls on the next tick
    wr(ADDR_TCTRL, 8'h00);
    wr(ADDR_TMODE, 8'h00);
    wr(ADDR_TL0, 8'h1f);
    wr(ADDR_TH0, 8'hff);
    wr(ADDR_TCTRL, 8'h10);
    wait_bit("ovf_13bit", 2, 1'b1);
    wr(ADDR_TCTRL, 8'h00);
    rchk("th0_13bit", ADDR_TH0, 32'h00);
    rchk("ctrl_sw_clear", ADDR_TCTRL, 32'h00);
    // Auto-reload
    wr(ADDR_TMODE, 8'h02);
    wr(ADDR_TH0, 8'hf0);
    wr(ADDR_TL0, 8'hfe);
    wr(ADDR_TCTRL, 8'h10);
    wait_bit("ovf_reload", 2, 1'b1);
    wr(ADDR_TCTRL, 8'h10);
    wait_bit("ovf_reload2", 2, 1'b1);
    wr(ADDR_TCTRL, 8'h00);
    rchk("th0_kept", ADDR_TH0, 32'hf0);
    // Split: high byte of timer 0 runs on the second run bit
    wr(ADDR_TMODE, 8'h33);
    wr(ADDR_TH0, 8'hff);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TL1, 8'h55);
    wr(ADDR_TCTRL, 8'h40);
    wait_bit("split_hi_ovf", 3, 1'b1);
    rchk("split_lo_idle", ADDR_TL0, 32'h00);
    rchk("t1_stopped", ADDR_TL1, 32'h55);
    // Second timer leaves its own split mode and counts from the next cycle
    wr(ADDR_TMODE, 8'h13);
    rchk("t1_runs", ADDR_TL1, 32'h56);
    // Event counting on the count pin
    wr(ADDR_TCTRL, 8'h00);
    wr(ADDR_TMODE, 8'h05);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TCTRL, 8'h10);
    i_dtc_pin_model.pulse(0, 5);
    rchk("events", ADDR_TL0, 32'h05);
    // External interrupt b: edge type, then level type
    wr(ADDR_TCTRL, 8'h00);
    i_dtc_pin_model.set_gate(1, 1'b1);
    wr(ADDR_TCTRL, 8'h04);
    i_dtc_pin_model.set_gate(1, 1'b0);
    wait_bit("edge_req", 5, 1'b1);
    rchk("edge_flag", ADDR_TCTRL, 32'h0c);
    ack(1, 1'b1);
    wait_bit("edge_ack", 5, 1'b0);
    wr(ADDR_TCTRL, 8'h00);
    wait_bit("level_low", 5, 1'b1);
    i_dtc_pin_model.set_gate(1, 1'b1);
    wait_bit("level_high", 5, 1'b0);
    // PWM with a low period inside the legal range
    wr(ADDR_TMODE, 8'h02);
    wr(ADDR_TMODE_HI, 8'h01);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TH0, 8'h40);
    wr(ADDR_TCTRL, 8'h10);
    run_len(0);
    chk("pwm_high", 32'd192, hi);
    chk("pwm_low", 32'd64, lo);
    run_len(2);
    chk("flag_high", 32'd192, hi);
    chk("flag_low", 32'd64, lo);
    wr(ADDR_TH0, 8'h00);
    repeat (300) @(posedge core_clk);
    wait_bit("pwm_force_hi", 0, 1'b1);
    wr(ADDR_TH0, 8'hff);
    repeat (300) @(posedge core_clk);
    wait_bit("pwm_force_lo", 0, 1'b0);
    // Toggle output on reload overflow
    wr(ADDR_TCTRL, 8'h00);
    wr(ADDR_TMODE_HI, 8'h00);
    wr(ADDR_TMODE, 8'h02);
    wr(ADDR_TH0, 8'hf0);
    wr(ADDR_TL0, 8'hf0);
    wr(ADDR_AUX, 8'h01);
    wait_bit("tog_init", 0, 1'b1);
    chk("tog_oe_b", 32'h0, {31'h0, pin_oe_b[0]});
    wr(ADDR_TCTRL, 8'h10);
    run_len(0);
    chk("tog_high", 32'd16, hi);
    chk("tog_low", 32'd16, lo);
    tally_and_finish();
  end
endmodule : dual_timer_counter_modes_bench
